// ==== common/clk_rst_pkg.sv ====
// constants, encodings and field layout shared by the clock/reset sequencer and its phase aligner
// assumes a single 250 MHz mclk that stands for the command clock domain
`default_nettype none
package clk_rst_pkg;
  localparam int MCLK_MHZ         = 250;
  localparam int POR_DELAY_MS     = 10;
  // delay scales linearly with the external timing capacitor
  localparam int POR_CAP_NF       = 5;
  localparam int POR_DELAY_CYCLES = POR_DELAY_MS * 1000 * MCLK_MHZ;
  localparam int OSC_MHZ          = 1280;
  localparam int CMD_CLK_MHZ      = 160;
  localparam int FINE_CLK_MHZ     = 640;
  localparam int CMD_DIVIDE       = OSC_MHZ / CMD_CLK_MHZ;
  localparam int FINE_DIVIDE      = OSC_MHZ / FINE_CLK_MHZ;
  localparam int PROMPT_DIVIDE    = 8;
  localparam int EXT_DIVIDE       = 1;
  localparam int PHASE_STEP_PS    = 1600;
  localparam int XING_PHASES      = 4;
  localparam int ALIGN_POS        = 3;
  localparam int LOCK_SYNCS       = 4;
  localparam int LOSS_CYCLES      = 1024;
  localparam int DELAY_W          = 5;
  localparam logic [15:0] SYNC_PATTERN = 16'hc3a5;
  localparam int ADDR_W           = 8;
  localparam int DATA_W           = 16;
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] DELAY_ADDR  = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam int CTRL_EXT_SER     = 0;
  localparam int CTRL_DUAL_INV    = 1;
  localparam int CTRL_PIX_DEF     = 2;
  localparam logic [2:0] CTRL_RESET  = 3'h4;
  localparam logic [4:0] DELAY_RESET = 5'h00;
  localparam int ST_CRU_LOCK      = 0;
  localparam int ST_ALIGN_LOCK    = 1;
  localparam int ST_PHASE_LO      = 2;
  localparam int ST_STRAP         = 4;
  localparam int ST_LOGIC_RST     = 5;
  typedef enum logic [2:0] {SRC_OSC = 3'b001, SRC_EXT_CMD = 3'b010, SRC_EXT_SER = 3'b100} clk_source_e;
  typedef enum logic [2:0] {ST_HUNT = 3'b001, ST_SLIP = 3'b010, ST_LOCKED = 3'b100} align_state_e;

  // serializer and fine-delay clocks share one selection
  function automatic clk_source_e fast_source(input logic strap, input logic ext_ser);
    if (ext_ser)
      return SRC_EXT_SER;
    else if (strap)
      return SRC_EXT_CMD;
    else
      return SRC_OSC;
  endfunction
endpackage
`default_nettype wire

// ==== common/aligner_if.sv ====
// signals between the sequencer core and the lane phase aligner
// assumes both ends run on the same command clock
`timescale 1ns/1ns
`default_nettype none
interface aligner_if;
  logic       cmd_bit;
  logic       logic_reset;
  logic       locked;
  logic       crossing_clock;
  logic [1:0] phase;
  modport core    (output cmd_bit, output logic_reset, input locked, input crossing_clock, input phase);
  modport aligner (input cmd_bit, input logic_reset, output locked, output crossing_clock, output phase);
endinterface
`default_nettype wire

// ==== src/lane_phase_aligner.sv ====
// lane phase aligner: divides the command clock by four into the crossing clock and slides its phase
// assumes one command-stream bit per mclk cycle and a synchronous logic reset from the core
`timescale 1ns/1ns
`default_nettype none
module lane_phase_aligner #(
  parameter logic [15:0] SYNC_PATTERN = clk_rst_pkg::SYNC_PATTERN,
  parameter int          LOCK_SYNCS   = clk_rst_pkg::LOCK_SYNCS,
  parameter int          LOSS_CYCLES  = clk_rst_pkg::LOSS_CYCLES
)(
  input wire logic     mclk,
  aligner_if.aligner   link
);
  localparam int LW = $clog2(LOSS_CYCLES + 1);
  localparam int GW = $clog2(LOCK_SYNCS + 1);

  logic [15:0]               shift;
  logic [1:0]                div_cnt;
  logic [1:0]                next_div_cnt;
  logic [LW-1:0]             silence;
  logic [GW-1:0]             good;
  clk_rst_pkg::align_state_e state;
  logic                      sync_hit;
  logic                      on_phase;
  logic                      lost;

  assign sync_hit = (shift == SYNC_PATTERN);
  assign on_phase = (div_cnt == 2'(clk_rst_pkg::ALIGN_POS));
  assign lost = (silence == LW'(LOSS_CYCLES - 1)) && !sync_hit;
  // a slip stretches one half period by one mclk cycle instead of jumping, so the clock never glitches or stops
  assign next_div_cnt = (state == clk_rst_pkg::ST_SLIP) ? div_cnt : div_cnt + 2'h1;

  always_ff @(posedge mclk)
  begin
    if (link.logic_reset)
      shift <= 16'h0000;
    else
      shift <= {shift[14:0], link.cmd_bit};
  end

  always_ff @(posedge mclk)
  begin
    if (link.logic_reset)
    begin
      div_cnt <= 2'h0;
      link.crossing_clock <= 1'b1;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      link.crossing_clock <= (next_div_cnt < 2'h2);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (link.logic_reset || sync_hit)
      silence <= '0;
    else if (silence != LW'(LOSS_CYCLES - 1))
      silence <= silence + LW'(1);
  end

  always_ff @(posedge mclk)
  begin
    if (link.logic_reset)
    begin
      state <= clk_rst_pkg::ST_HUNT;
      good <= '0;
      link.locked <= 1'b0;
      link.phase <= 2'h0;
    end
    else
    begin
      case (state)
        clk_rst_pkg::ST_HUNT:
        begin
          if (sync_hit && on_phase)
          begin
            good <= good + GW'(1);
            if (good == GW'(LOCK_SYNCS - 1))
            begin
              state <= clk_rst_pkg::ST_LOCKED;
              link.locked <= 1'b1;
            end
          end
          else if (sync_hit || lost)
          begin
            good <= '0;
            if (sync_hit)
              state <= clk_rst_pkg::ST_SLIP;
          end
        end
        clk_rst_pkg::ST_SLIP:
        begin
          link.phase <= link.phase + 2'h1;
          state <= clk_rst_pkg::ST_HUNT;
        end
        clk_rst_pkg::ST_LOCKED:
        begin
          // absent or misplaced syncs drop lock; the clock keeps running at its last phase
          if ((sync_hit && !on_phase) || lost)
          begin
            state <= clk_rst_pkg::ST_HUNT;
            good <= '0;
            link.locked <= 1'b0;
          end
        end
        default:
        begin
          state <= clk_rst_pkg::ST_HUNT;
          link.locked <= 1'b0;
        end
      endcase
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (link.logic_reset);

  xing_high_a: assert property (link.crossing_clock |-> ##[1:3] !link.crossing_clock)
    else $error("crossing clock stuck high");
  xing_low_a: assert property (!link.crossing_clock |-> ##[1:3] link.crossing_clock)
    else $error("crossing clock stuck low");
  lock_on_sync_a: assert property ($rose(link.locked) |-> $past(sync_hit) && $past(on_phase))
    else $error("lock without an on-phase sync");
  slip_hold_a: assert property (state == clk_rst_pkg::ST_SLIP |=> $stable(div_cnt) ##1 !$stable(div_cnt))
    else $error("slip did not stretch one cycle");
  loss_unlock_a: assert property (state == clk_rst_pkg::ST_LOCKED && lost |=> !link.locked)
    else $error("lock kept after stream loss");
endmodule
`default_nettype wire

// ==== src/clock_and_reset_sequencing.sv ====
// clock source selection, crossing-clock derivation and reset sequencing of the chip bottom
// assumes mclk is the running command clock and all pins are synchronous to it
//
// How it works
// - bypass strap high selects external command clock; fast clocks derive from it.
// - a control bit selects an external serializer clock, also used as fine-delay clock.
// - internally, command and fine-delay clocks divide the locked oscillator clock.
// - the crossing clock divides the command clock by four, one of four phases.
// - sync symbols in the command stream pick the crossing-clock phase.
// - without a stream the crossing clock keeps running; phase moves without stopping.
// - a programmable delay in 1.6 ns steps drives command clock and stream shifters.
// - a control bit adds a two-inverter delay on the phase-shifter clock.
// - the clock-recovery lock shows on the status pad.
// - an event clear resets matrix and bottom data-path logic.
// - test-port reset follows the debug enable pad, in reset by default.
// - supply-up reset starts low and releases 10 ms after supply rise.
// - supply-up reset asynchronously loads defaults into global configuration.
// - a control bit selects hard-wired or stored pixel configuration.
// - supply-up reset is synchronised into the command clock as logic reset.
// - unlocked recovery still gives a prompt clock at oscillator divided by eight.
// - logic reset acts on aligner and decoder, which start after release.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module clock_and_reset_sequencing #(
  parameter int POR_DELAY_CYCLES = clk_rst_pkg::POR_DELAY_CYCLES,
  parameter int DELAY_W          = clk_rst_pkg::DELAY_W
)(
  input  wire logic                           mclk,
  input  wire logic                           reset,
  input  wire logic                           supply_above_threshold,
  input  wire logic                           recovery_bypass_strap,
  input  wire logic                           cru_locked,
  input  wire logic                           cmd_serial_bit,
  input  wire logic                           event_clear_command,
  input  wire logic                           debug_enable_pad,
  input  wire logic [clk_rst_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [clk_rst_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                           reg_write,
  input  wire logic                           reg_read,
  output logic      [clk_rst_pkg::DATA_W-1:0] reg_rdata,
  output logic                                supply_reset_n,
  output logic                                logic_reset,
  output logic                                crossing_clock,
  output logic      [2:0]                     cmd_clk_source,
  output logic      [2:0]                     serializer_clk_source,
  output logic      [2:0]                     fine_delay_clk_source,
  output logic      [3:0]                     cmd_clk_divide,
  output logic      [DELAY_W-1:0]             phase_shift_code,
  output logic                                dual_inverter_delay,
  output logic                                pixel_default_select,
  output logic                                status_pad,
  output logic                                matrix_data_reset,
  output logic                                bottom_data_reset,
  output logic                                test_port_reset_n
);
  localparam int TW = $clog2(POR_DELAY_CYCLES + 1);

  logic [TW-1:0]                     por_timer;
  logic [1:0]                        sync_stage;
  logic [2:0]                        ctrl;
  logic [DELAY_W-1:0]                delay_code;
  logic [clk_rst_pkg::DATA_W-1:0]    read_word;
  clk_rst_pkg::clk_source_e          next_fast_source;

  aligner_if link ();

  assign link.cmd_bit = cmd_serial_bit;
  assign link.logic_reset = logic_reset;
  assign crossing_clock = link.crossing_clock;

  lane_phase_aligner u_aligner (
    .mclk (mclk),
    .link (link)
  );

  // supply-up timer: held low until the supply has stayed up for the full delay
  always_ff @(posedge mclk)
  begin
    if (reset || !supply_above_threshold)
    begin
      por_timer <= '0;
      supply_reset_n <= 1'b0;
    end
    else if (!supply_reset_n)
    begin
      if (por_timer == TW'(POR_DELAY_CYCLES - 1))
        supply_reset_n <= 1'b1;
      else
        por_timer <= por_timer + TW'(1);
    end
  end

  // release only after three command-clock edges; assertion needs no clock edge
  always_ff @(posedge mclk or negedge supply_reset_n)
  begin
    if (!supply_reset_n)
      sync_stage <= 2'h3;
    else
      sync_stage <= {sync_stage[0], 1'b0};
  end

  always_ff @(posedge mclk or negedge supply_reset_n)
  begin
    if (!supply_reset_n)
      logic_reset <= 1'b1;
    else
      logic_reset <= sync_stage[1] | reset;
  end

  // global configuration takes its defaults the moment supply-up reset goes low
  always_ff @(posedge mclk or negedge supply_reset_n)
  begin
    if (!supply_reset_n)
    begin
      ctrl <= clk_rst_pkg::CTRL_RESET;
      delay_code <= DELAY_W'(clk_rst_pkg::DELAY_RESET);
    end
    else if (reset)
    begin
      ctrl <= clk_rst_pkg::CTRL_RESET;
      delay_code <= DELAY_W'(clk_rst_pkg::DELAY_RESET);
    end
    else if (reg_write)
    begin
      case (reg_addr)
        clk_rst_pkg::CTRL_ADDR:
          ctrl <= reg_wdata[2:0];
        clk_rst_pkg::DELAY_ADDR:
          delay_code <= reg_wdata[DELAY_W-1:0];
        default:
          ;
      endcase
    end
  end

  always_comb
  begin
    read_word = '0;
    case (reg_addr)
      clk_rst_pkg::CTRL_ADDR:
        read_word[2:0] = ctrl;
      clk_rst_pkg::DELAY_ADDR:
        read_word[DELAY_W-1:0] = delay_code;
      clk_rst_pkg::STATUS_ADDR:
      begin
        read_word[clk_rst_pkg::ST_CRU_LOCK] = cru_locked;
        read_word[clk_rst_pkg::ST_ALIGN_LOCK] = link.locked;
        read_word[clk_rst_pkg::ST_PHASE_LO +: 2] = link.phase;
        read_word[clk_rst_pkg::ST_STRAP] = recovery_bypass_strap;
        read_word[clk_rst_pkg::ST_LOGIC_RST] = logic_reset;
      end
      default:
        read_word = '0;
    endcase
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (reset || !reg_read)
      reg_rdata <= '0;
    else
      reg_rdata <= read_word;
  end

  assign next_fast_source = clk_rst_pkg::fast_source(recovery_bypass_strap, ctrl[clk_rst_pkg::CTRL_EXT_SER]);

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cmd_clk_source <= clk_rst_pkg::SRC_OSC;
      serializer_clk_source <= clk_rst_pkg::SRC_OSC;
      fine_delay_clk_source <= clk_rst_pkg::SRC_OSC;
      cmd_clk_divide <= 4'(clk_rst_pkg::PROMPT_DIVIDE);
    end
    else
    begin
      serializer_clk_source <= next_fast_source;
      fine_delay_clk_source <= next_fast_source;
      if (recovery_bypass_strap)
      begin
        cmd_clk_source <= clk_rst_pkg::SRC_EXT_CMD;
        cmd_clk_divide <= 4'(clk_rst_pkg::EXT_DIVIDE);
      end
      else
      begin
        // locked or not, the oscillator divide gives the logic a prompt clock
        cmd_clk_source <= clk_rst_pkg::SRC_OSC;
        cmd_clk_divide <= 4'(clk_rst_pkg::CMD_DIVIDE);
      end
    end
  end

  // one code steers both the command-clock and the stream shifter, like a cable delay
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      phase_shift_code <= '0;
      dual_inverter_delay <= 1'b0;
      pixel_default_select <= clk_rst_pkg::CTRL_RESET[clk_rst_pkg::CTRL_PIX_DEF];
    end
    else
    begin
      phase_shift_code <= delay_code;
      dual_inverter_delay <= ctrl[clk_rst_pkg::CTRL_DUAL_INV];
      pixel_default_select <= ctrl[clk_rst_pkg::CTRL_PIX_DEF];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      status_pad <= 1'b0;
    else
      status_pad <= cru_locked;
  end

  // no clear is made here on power-up; the control system must send one
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      matrix_data_reset <= 1'b0;
      bottom_data_reset <= 1'b0;
    end
    else
    begin
      matrix_data_reset <= event_clear_command;
      bottom_data_reset <= event_clear_command;
    end
  end

  // a floating pad is pulled low outside, so the test port rests in reset
  always_ff @(posedge mclk)
  begin
    if (reset)
      test_port_reset_n <= 1'b0;
    else
      test_port_reset_n <= debug_enable_pad;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  sequence supply_up_s;
    $rose(supply_reset_n);
  endsequence

  sequence release_s;
    logic_reset [*3] ##1 !logic_reset;
  endsequence

  sequence ctrl_write_s;
    reg_write && reg_addr == clk_rst_pkg::CTRL_ADDR;
  endsequence

  por_delay_a: assert property (supply_up_s |-> $past(por_timer) == TW'(POR_DELAY_CYCLES - 1))
    else $error("supply reset released early or late");
  por_low_a: assert property (!supply_above_threshold |=> !supply_reset_n)
    else $error("supply reset not held with supply low");
  sync_release_a: assert property (supply_up_s |-> release_s)
    else $error("logic reset release not two stages");
  logic_hold_a: assert property (!supply_reset_n |-> logic_reset)
    else $error("logic reset low under supply reset");
  bypass_src_a: assert property (recovery_bypass_strap |=> cmd_clk_source == clk_rst_pkg::SRC_EXT_CMD
                                 && cmd_clk_divide == 4'(clk_rst_pkg::EXT_DIVIDE))
    else $error("bypass strap did not select external clock");
  ext_ser_a: assert property (ctrl[clk_rst_pkg::CTRL_EXT_SER] |=>
                              serializer_clk_source == clk_rst_pkg::SRC_EXT_SER
                              && fine_delay_clk_source == clk_rst_pkg::SRC_EXT_SER)
    else $error("external serializer clock not used");
  internal_a: assert property (!recovery_bypass_strap |=> cmd_clk_divide == 4'(clk_rst_pkg::PROMPT_DIVIDE))
    else $error("internal command clock divide wrong");
  pixel_default_select_a: assert property (reg_write && reg_addr == clk_rst_pkg::CTRL_ADDR ##1 !reg_write
                             |=> pixel_default_select == $past(reg_wdata[clk_rst_pkg::CTRL_PIX_DEF], 2))
    else $error("pixel default select not from control");
  clear_a: assert property (event_clear_command |=> matrix_data_reset && bottom_data_reset ##1
                            (matrix_data_reset == $past(event_clear_command)))
    else $error("event clear not passed to data path");
  status_a: assert property (cru_locked ##1 cru_locked |-> ##1 status_pad)
    else $error("lock not shown on status pad");
  test_port_a: assert property (!debug_enable_pad |=> !test_port_reset_n)
    else $error("test port left reset without the pad");
  rdata_a: assert property (!reg_read |=> reg_rdata == '0)
    else $error("read data outside the answer cycle");
  // configuration outputs trail the register by one cycle
  delay_follow_a: assert property (reg_write && reg_addr == clk_rst_pkg::DELAY_ADDR |=> ##1
                                   phase_shift_code == $past(reg_wdata[DELAY_W-1:0], 2))
    else $error("phase shift code not from delay register");
  dual_inv_a: assert property (ctrl_write_s |=> ##1
                               dual_inverter_delay == $past(reg_wdata[clk_rst_pkg::CTRL_DUAL_INV], 2))
    else $error("dual inverter delay not from control");
  clear_idle_a: assert property (!event_clear_command |=> !matrix_data_reset && !bottom_data_reset)
    else $error("data reset without event clear");
  tp_release_a: assert property (debug_enable_pad |=> test_port_reset_n)
    else $error("test port held in reset with pad high");
  status_low_a: assert property (!cru_locked |=> !status_pad)
    else $error("lock shown without recovery lock");
  cfg_default_a: assert property (!supply_reset_n |-> ctrl == clk_rst_pkg::CTRL_RESET
                                  && delay_code == DELAY_W'(clk_rst_pkg::DELAY_RESET))
    else $error("configuration not at defaults under supply reset");
  internal_src_a: assert property (!recovery_bypass_strap && !ctrl[clk_rst_pkg::CTRL_EXT_SER] |=>
                                   serializer_clk_source == clk_rst_pkg::SRC_OSC)
    else $error("internal serializer source not the oscillator");
  aligner_reset_a: assert property (logic_reset |=> !link.locked)
    else $error("aligner lock survived logic reset");
endmodule
`default_nettype wire

// ==== dv/command_source.sv ====
// far-side model: serial command stream and event clear pulses
// assumes one stream bit per mclk and that the testbench asks for each clear
`timescale 1ns/1ns
`default_nettype none
module command_source (
  input  wire logic mclk,
  input  wire logic send_syncs,
  input  wire logic clear_req,
  output logic      cmd_serial_bit,
  output logic      event_clear_command
);
  logic [3:0] bit_idx = 4'hf;
  logic       ser     = 1'b0;
  logic       clr     = 1'b0;
  assign cmd_serial_bit      = ser;
  assign event_clear_command = clr;
  // an idle line toggles so a stale level can never pass for a sync symbol
  always @(posedge mclk)
  begin
    bit_idx <= bit_idx - 4'h1;
    ser     <= send_syncs ? clk_rst_pkg::SYNC_PATTERN[bit_idx] : ~ser;
    clr     <= clear_req;
  end
endmodule
`default_nettype wire

// ==== dv/test_clock_and_reset_sequencing.sv ====
// testbench for the clock and reset sequencer with a far-side command source
// assumes a shortened supply-up delay of 20 cycles and a free-running 250 MHz mclk
`timescale 1ns/1ns
`default_nettype none
module test_clock_and_reset_sequencing;
  localparam int POR_CYC = 20;
  logic        mclk       = 1'b0;
  logic        reset      = 1'b1;
  logic        supply_up  = 1'b0;
  logic        strap      = 1'b0;
  logic        cru_locked = 1'b0;
  logic        debug_pad  = 1'b0;
  logic [7:0]  reg_addr   = 8'h00;
  logic [15:0] reg_wdata  = 16'h0000;
  logic        reg_write  = 1'b0;
  logic        reg_read   = 1'b0;
  logic        send_syncs = 1'b0;
  logic        clear_req  = 1'b0;
  logic        cmd_bit, clear_cmd, supply_reset_n, logic_reset, xclk;
  logic        dual_inv, pix_def, status_pad, m_rst, b_rst, tp_rst_n, prev_x;
  logic [15:0] rdata, rd, ctrl, dly;
  logic [2:0]  cmd_src, ser_src, fine_src;
  logic [3:0]  divide;
  logic [4:0]  phase_code;
  int          err_count = 0;
  int          tests_run = 0;
  int          run_len   = 0;
  int          edges     = 0;
  int          n;

  always #2 mclk = ~mclk;

  clock_and_reset_sequencing #(.POR_DELAY_CYCLES(POR_CYC), .DELAY_W(5)) u_dut (
    .mclk(mclk), .reset(reset), .supply_above_threshold(supply_up),
    .recovery_bypass_strap(strap), .cru_locked(cru_locked), .cmd_serial_bit(cmd_bit),
    .event_clear_command(clear_cmd), .debug_enable_pad(debug_pad), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata),
    .supply_reset_n(supply_reset_n), .logic_reset(logic_reset), .crossing_clock(xclk),
    .cmd_clk_source(cmd_src), .serializer_clk_source(ser_src), .fine_delay_clk_source(fine_src),
    .cmd_clk_divide(divide), .phase_shift_code(phase_code), .dual_inverter_delay(dual_inv),
    .pixel_default_select(pix_def), .status_pad(status_pad), .matrix_data_reset(m_rst),
    .bottom_data_reset(b_rst), .test_port_reset_n(tp_rst_n)
  );

  command_source u_far (
    .mclk(mclk), .send_syncs(send_syncs), .clear_req(clear_req),
    .cmd_serial_bit(cmd_bit), .event_clear_command(clear_cmd)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic [2:0] exp_fast(input logic s, input logic e);
    return e ? 3'h4 : (s ? 3'h2 : 3'h1);
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // a crossing-clock half longer than three cycles means it stalled
  always @(posedge mclk)
  begin
    if (reset || logic_reset)
      run_len = 0;
    else if (xclk !== prev_x)
    begin
      run_len = 1;
      edges++;
    end
    else
      run_len++;
    if (run_len > 3)
    begin
      err_count++;
      $display("BAD %0t crossing clock stalled", $time);
    end
    prev_x = xclk;
  end

  initial
  begin
    #40000;
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end

  initial
  begin
    void'($urandom(99820));
    cycles(16);
    check(supply_reset_n, 16'h0, "supply reset low");
    check(logic_reset, 16'h1, "logic reset held");
    check(cmd_src, 16'h1, "oscillator source");
    check(divide, 16'h8, "prompt divide");
    check(pix_def, 16'h1, "pixel default");
    check(tp_rst_n, 16'h0, "test port reset");
    // the clock already runs before the supply rises
    @(posedge mclk);
    reset     <= 1'b0;
    supply_up <= 1'b1;
    n = 0;
    while (supply_reset_n !== 1'b1 && n < 40)
    begin
      cycles(1);
      n++;
    end
    check(16'(n >= POR_CYC - 1 && n <= POR_CYC + 1), 16'h1, "supply reset delay");
    n = 0;
    while (logic_reset !== 1'b0 && n < 10)
    begin
      cycles(1);
      n++;
    end
    check(16'(n), 16'h3, "logic reset release");
    check(m_rst, 16'h0, "no automatic clear");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      strap <= i[1];
      reg_wr(clk_rst_pkg::CTRL_ADDR, {13'h0000, 2'h2, i[0]});
      cycles(3);
      check(cmd_src, i[1] ? 16'h2 : 16'h1, "command source");
      check(ser_src, exp_fast(i[1], i[0]), "serializer source");
      check(fine_src, exp_fast(i[1], i[0]), "fine source");
      check(divide, i[1] ? 16'h1 : 16'h8, "command divide");
    end
    for (int i = 0; i < 8; i++)
    begin
      ctrl = 16'($urandom());
      dly  = 16'($urandom());
      reg_wr(clk_rst_pkg::CTRL_ADDR, ctrl);
      reg_wr(clk_rst_pkg::DELAY_ADDR, dly);
      reg_wr(clk_rst_pkg::STATUS_ADDR, 16'hffff);
      reg_rd(clk_rst_pkg::CTRL_ADDR, rd);
      check(rd, {13'h0000, ctrl[2:0]}, "control readback");
      reg_rd(clk_rst_pkg::DELAY_ADDR, rd);
      check(rd, {11'h000, dly[4:0]}, "delay readback");
      reg_rd(8'h0c + 8'($urandom_range(0, 3)) * 8'h04, rd);
      check(rd, 16'h0000, "unmapped read");
      check(phase_code, dly[4:0], "phase code");
      check(dual_inv, ctrl[1], "dual inverter");
      check(pix_def, ctrl[2], "pixel select");
    end
    for (int i = 0; i < 16; i++)
    begin
      @(posedge mclk);
      cru_locked <= 1'($urandom());
      debug_pad  <= 1'($urandom());
      cycles(1);
      check(status_pad, cru_locked, "status pad");
      check(tp_rst_n, debug_pad, "test port reset");
    end
    reg_rd(clk_rst_pkg::STATUS_ADDR, rd);
    check(rd[0], cru_locked, "status lock bit");
    check(rd[4], strap, "status strap bit");
    cycles(1);
    check(rdata, 16'h0000, "read data stands one cycle");
    @(posedge mclk);
    clear_req <= 1'b1;
    @(posedge mclk);
    clear_req <= 1'b0;
    cycles(1);
    check({m_rst, b_rst}, 16'h3, "data resets");
    cycles(1);
    check({m_rst, b_rst}, 16'h0, "data reset pulse");
    n = edges;
    cycles(40);
    check(16'(edges - n), 16'd20, "crossing clock rate");
    @(posedge mclk);
    send_syncs <= 1'b1;
    cycles(256);
    reg_rd(clk_rst_pkg::STATUS_ADDR, rd);
    check(rd[1], 16'h1, "aligner lock");
    @(posedge mclk);
    send_syncs <= 1'b0;
    cycles(1100);
    reg_rd(clk_rst_pkg::STATUS_ADDR, rd);
    check(rd[1], 16'h0, "lock lost");
    // a supply dip alone reloads the defaults through the supply-up reset
    reg_wr(clk_rst_pkg::CTRL_ADDR, 16'h0003);
    @(posedge mclk);
    supply_up <= 1'b0;
    @(posedge mclk);
    supply_up <= 1'b1;
    cycles(2);
    check({pix_def, supply_reset_n, logic_reset}, 16'h5, "supply dip reset");
    reg_rd(clk_rst_pkg::CTRL_ADDR, rd);
    check(rd, 16'(clk_rst_pkg::CTRL_RESET), "supply dip defaults");
    n = 0;
    while (logic_reset !== 1'b0 && n < 40)
    begin
      cycles(1);
      n++;
    end
    check(16'(n >= POR_CYC - 2 && n <= POR_CYC), 16'h1, "supply dip release");
    reg_wr(clk_rst_pkg::CTRL_ADDR, 16'h0000);
    cycles(2);
    check(pix_def, 16'h0, "pixel select cleared");
    // a second reset in mid-run reloads the defaults
    @(posedge mclk);
    reset <= 1'b1;
    cycles(3);
    check({pix_def, logic_reset}, 16'h3, "second reset");
    test_done();
  end
endmodule
`default_nettype wire
